/* File: hdl/iss_map.vh */
`ifndef ISS_MAP_VH
`define ISS_MAP_VH
// register indices (printed offsets are not multiples of four)
`define ISS_IDX_PWM 8'h18
`define ISS_IDX_DAC 8'h19
`define ISS_IDX_TMR 8'h1a
// byte address = index * 4
`define ISS_ADDR_PWM 12'h060
`define ISS_ADDR_DAC 12'h064
`define ISS_ADDR_TMR 12'h068
// write masks: reserved bits forced to zero
`define ISS_MASK_PWM 16'h29ff
`define ISS_MASK_DAC 16'h0077
`define ISS_MASK_TMR 16'h1110
`define ISS_RST_VAL 16'h0000
// field positions
`define ISS_FAULT2_BIT 13
`define ISS_FAULT1_BIT 11
`define ISS_PAIR2_MSB 8
`define ISS_PAIR2_LSB 6
`define ISS_PAIR1_MSB 5
`define ISS_PAIR1_LSB 3
`define ISS_PAIR0_MSB 2
`define ISS_PAIR0_LSB 0
`define ISS_DAC1_MSB 6
`define ISS_DAC1_LSB 4
`define ISS_DAC0_MSB 2
`define ISS_DAC0_LSB 0
`define ISS_TIN3_BIT 12
`define ISS_TIN2_BIT 8
`define ISS_TIN1_BIT 4
// pair source codes
`define ISS_PSRC_PIN 3'h0
`define ISS_PSRC_TMR 3'h1
`define ISS_PSRC_ADC 3'h2
`define ISS_PSRC_CMPA 3'h3
`define ISS_PSRC_CMPB 3'h4
// dac sync codes
`define ISS_DS_IT0 3'h0
`define ISS_DS_IT1 3'h1
`define ISS_DS_IT2 3'h2
`define ISS_DS_PWMS 3'h3
`define ISS_DS_TA0 3'h4
`define ISS_DS_TA1 3'h5
`endif

/* File: hdl/iss_source_select.v */
// Functional notes
// - fault 2 input: fault pin when bit 13 clear, comparator B when set
// - fault 1 input: fault pin when bit 11 clear, comparator A when set
// - pair 2 field bits 8-6: reserved, timer ch3, adc slot2, cmp A, cmp B
// - pair 2 adc mode: above high limit 2 gives 4 low 5 high, below low gives reverse
// - pair 1 field bits 5-3: pin, timer ch2, adc slot1, cmp A, cmp B
// - pair 1 adc mode: above high limit 1 gives 2 low 3 high, below low 2 reverse
// - pair 0 field bits 2-0: pin, timer ch0, adc slot0, cmp A, cmp B
// - pair 0 adc mode: above high limit 1 gives 0 low 1 high, below low 2 reverse
// - dac1 sync bits 6-4: three interval timers, pwm reload, timer ch0, ch1
// - dac0 sync bits 2-0: same encoding as dac1
// - timer input 3: pin when bit 12 clear, pwm reload sync when set
// - timer input 2: pin when bit 8 clear, comparator B when set
// - timer input 1: pin when bit 4 clear, comparator A when set
//
// The APB interface to the registers was left to the implementer.
`include "iss_map.vh"
`timescale 1ns/1ns
`default_nettype none
module iss_source_select (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire fault1_pin,
  input wire fault2_pin,
  input wire pair0_external_source,
  input wire pair1_external_source,
  input wire timer_in1_pin,
  input wire timer_in2_pin,
  input wire timer_in3_pin,
  input wire comparator_a_out,
  input wire comparator_b_out,
  input wire timer_a_ch0,
  input wire timer_a_ch1,
  input wire timer_a_ch2,
  input wire timer_a_ch3,
  input wire interval_timer_0,
  input wire interval_timer_1,
  input wire interval_timer_2,
  input wire pwm_reload_sync,
  input wire [11:0] adc_result_slot0,
  input wire [11:0] adc_result_slot1,
  input wire [11:0] adc_result_slot2,
  input wire [11:0] high_limit_1,
  input wire [11:0] high_limit_2,
  input wire [11:0] low_limit_2,
  output reg pwm_fault1_in,
  output reg pwm_fault2_in,
  output reg pair0_source,
  output reg pair1_source,
  output reg pair2_source,
  output reg [5:0] pwm_adc_force,
  output reg [5:0] pwm_adc_force_en,
  output reg dac0_sync_in,
  output reg dac1_sync_in,
  output reg timer_a_in1,
  output reg timer_a_in2,
  output reg timer_a_in3
);

  reg [15:0] pwm_sel_r;
  reg [15:0] dac_sel_r;
  reg [15:0] tmr_sel_r;
  reg [1:0] fault1_s_r;
  reg [1:0] fault2_s_r;
  reg [1:0] pair0_external_source_s_r;
  reg [1:0] pair1_external_source_s_r;
  reg [1:0] tin1_s_r;
  reg [1:0] tin2_s_r;
  reg [1:0] tin3_s_r;
  reg [31:0] prdata_nxt;
  reg f1_nxt;
  reg f2_nxt;
  reg p0_nxt;
  reg p1_nxt;
  reg p2_nxt;
  reg d0_nxt;
  reg d1_nxt;
  reg t1_nxt;
  reg t2_nxt;
  reg t3_nxt;
  reg [5:0] frc_nxt;
  reg [5:0] frc_en_nxt;

  // a write lands in the access phase only
  wire wr_en = psel & penable & pwrite;
  wire [15:0] wdat = pwdata[15:0];

  // pair source mux; reserved codes give low
  function pair_mux;
    input [2:0] code;
    input pin;
    input tmr;
    input cmpa;
    input cmpb;
    input pin_ok;
    begin
      case (code)
        `ISS_PSRC_PIN: pair_mux = pin & pin_ok;
        `ISS_PSRC_TMR: pair_mux = tmr;
        `ISS_PSRC_CMPA: pair_mux = cmpa;
        `ISS_PSRC_CMPB: pair_mux = cmpb;
        default: pair_mux = 1'b0;
      endcase
    end
  endfunction

  // adc limit compare: {force_en, even_val, odd_val}
  function [2:0] adc_lim;
    input [11:0] res;
    input [11:0] hi;
    input [11:0] lo;
    begin
      if (res > hi) begin
        adc_lim = 3'h5;
      end else if (res < lo) begin
        adc_lim = 3'h6;
      end else begin
        adc_lim = 3'h0;
      end
    end
  endfunction

  function sync_mux;
    input [2:0] code;
    input i0;
    input i1;
    input i2;
    input ps;
    input a0;
    input a1;
    begin
      case (code)
        `ISS_DS_IT0: sync_mux = i0;
        `ISS_DS_IT1: sync_mux = i1;
        `ISS_DS_IT2: sync_mux = i2;
        `ISS_DS_PWMS: sync_mux = ps;
        `ISS_DS_TA0: sync_mux = a0;
        `ISS_DS_TA1: sync_mux = a1;
        default: sync_mux = 1'b0;
      endcase
    end
  endfunction

  // no wait states and no error responses
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // pin synchronisers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault1_s_r <= 2'h0;
      fault2_s_r <= 2'h0;
      pair0_external_source_s_r <= 2'h0;
      pair1_external_source_s_r <= 2'h0;
      tin1_s_r <= 2'h0;
      tin2_s_r <= 2'h0;
      tin3_s_r <= 2'h0;
    end else begin
      fault1_s_r <= {fault1_s_r[0], fault1_pin};
      fault2_s_r <= {fault2_s_r[0], fault2_pin};
      pair0_external_source_s_r <= {pair0_external_source_s_r[0], pair0_external_source};
      pair1_external_source_s_r <= {pair1_external_source_s_r[0], pair1_external_source};
      tin1_s_r <= {tin1_s_r[0], timer_in1_pin};
      tin2_s_r <= {tin2_s_r[0], timer_in2_pin};
      tin3_s_r <= {tin3_s_r[0], timer_in3_pin};
    end
  end

  // register file
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_sel_r <= `ISS_RST_VAL;
      dac_sel_r <= `ISS_RST_VAL;
      tmr_sel_r <= `ISS_RST_VAL;
    end else if (wr_en) begin
      if (paddr == `ISS_ADDR_PWM) begin
        pwm_sel_r <= wdat & `ISS_MASK_PWM;
      end
      if (paddr == `ISS_ADDR_DAC) begin
        dac_sel_r <= wdat & `ISS_MASK_DAC;
      end
      if (paddr == `ISS_ADDR_TMR) begin
        tmr_sel_r <= wdat & `ISS_MASK_TMR;
      end
    end
  end

  // unmapped addresses read as zero
  always @* begin
    case (paddr)
      `ISS_ADDR_PWM: prdata_nxt = {16'h0000, pwm_sel_r};
      `ISS_ADDR_DAC: prdata_nxt = {16'h0000, dac_sel_r};
      `ISS_ADDR_TMR: prdata_nxt = {16'h0000, tmr_sel_r};
      default: prdata_nxt = 32'h00000000;
    endcase
  end

  // read data registered in the setup cycle, valid in the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= prdata_nxt;
    end
  end

  // pwm fault inputs
  always @* begin
    f2_nxt = pwm_sel_r[`ISS_FAULT2_BIT] ? comparator_b_out : fault2_s_r[1];
    f1_nxt = pwm_sel_r[`ISS_FAULT1_BIT] ? comparator_a_out : fault1_s_r[1];
  end

  // pair sources; adc mode and reserved codes leave the pair source low
  always @* begin : pair_logic
    reg [2:0] c0;
    reg [2:0] c1;
    reg [2:0] c2;
    c0 = pwm_sel_r[`ISS_PAIR0_MSB:`ISS_PAIR0_LSB];
    c1 = pwm_sel_r[`ISS_PAIR1_MSB:`ISS_PAIR1_LSB];
    c2 = pwm_sel_r[`ISS_PAIR2_MSB:`ISS_PAIR2_LSB];
    p0_nxt = pair_mux(c0, pair0_external_source_s_r[1], timer_a_ch0, comparator_a_out,
      comparator_b_out, 1'b1);
    p1_nxt = pair_mux(c1, pair1_external_source_s_r[1], timer_a_ch2, comparator_a_out,
      comparator_b_out, 1'b1);
    // pair 2 code 000 is reserved, so the pin path is disabled
    p2_nxt = pair_mux(c2, 1'b0, timer_a_ch3, comparator_a_out,
      comparator_b_out, 1'b0);
  end

  // adc limit forcing of the pair outputs
  always @* begin : force_logic
    reg [2:0] l0;
    reg [2:0] l1;
    reg [2:0] l2;
    l0 = adc_lim(adc_result_slot0, high_limit_1, low_limit_2);
    l1 = adc_lim(adc_result_slot1, high_limit_1, low_limit_2);
    l2 = adc_lim(adc_result_slot2, high_limit_2, low_limit_2);
    // in band: no forcing, the pwm keeps its own drive
    frc_nxt = 6'h00;
    frc_en_nxt = 6'h00;
    if (pwm_sel_r[`ISS_PAIR0_MSB:`ISS_PAIR0_LSB] == `ISS_PSRC_ADC) begin
      frc_en_nxt[1:0] = {l0[2], l0[2]};
      frc_nxt[1:0] = {l0[0], l0[1]};
    end
    if (pwm_sel_r[`ISS_PAIR1_MSB:`ISS_PAIR1_LSB] == `ISS_PSRC_ADC) begin
      frc_en_nxt[3:2] = {l1[2], l1[2]};
      frc_nxt[3:2] = {l1[0], l1[1]};
    end
    if (pwm_sel_r[`ISS_PAIR2_MSB:`ISS_PAIR2_LSB] == `ISS_PSRC_ADC) begin
      frc_en_nxt[5:4] = {l2[2], l2[2]};
      frc_nxt[5:4] = {l2[0], l2[1]};
    end
  end

  // dac sync inputs
  always @* begin
    d1_nxt = sync_mux(dac_sel_r[`ISS_DAC1_MSB:`ISS_DAC1_LSB], interval_timer_0,
      interval_timer_1, interval_timer_2, pwm_reload_sync, timer_a_ch0,
      timer_a_ch1);
    d0_nxt = sync_mux(dac_sel_r[`ISS_DAC0_MSB:`ISS_DAC0_LSB], interval_timer_0,
      interval_timer_1, interval_timer_2, pwm_reload_sync, timer_a_ch0,
      timer_a_ch1);
  end

  // timer a inputs
  always @* begin
    t3_nxt = tmr_sel_r[`ISS_TIN3_BIT] ? pwm_reload_sync : tin3_s_r[1];
    t2_nxt = tmr_sel_r[`ISS_TIN2_BIT] ? comparator_b_out : tin2_s_r[1];
    t1_nxt = tmr_sel_r[`ISS_TIN1_BIT] ? comparator_a_out : tin1_s_r[1];
  end

  // output flops: a selected on-chip source reaches its peripheral one edge later, a pin three edges later
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_fault1_in <= 1'b0;
      pwm_fault2_in <= 1'b0;
    end else begin
      pwm_fault1_in <= f1_nxt;
      pwm_fault2_in <= f2_nxt;
    end
  end

  // pair source flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pair0_source <= 1'b0;
      pair1_source <= 1'b0;
      pair2_source <= 1'b0;
    end else begin
      pair0_source <= p0_nxt;
      pair1_source <= p1_nxt;
      pair2_source <= p2_nxt;
    end
  end

  // adc force flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_adc_force <= 6'h00;
      pwm_adc_force_en <= 6'h00;
    end else begin
      pwm_adc_force <= frc_nxt;
      pwm_adc_force_en <= frc_en_nxt;
    end
  end

  // dac sync flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac0_sync_in <= 1'b0;
      dac1_sync_in <= 1'b0;
    end else begin
      dac0_sync_in <= d0_nxt;
      dac1_sync_in <= d1_nxt;
    end
  end

  // timer input flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_a_in1 <= 1'b0;
      timer_a_in2 <= 1'b0;
      timer_a_in3 <= 1'b0;
    end else begin
      timer_a_in1 <= t1_nxt;
      timer_a_in2 <= t2_nxt;
      timer_a_in3 <= t3_nxt;
    end
  end

endmodule // iss_source_select
`default_nettype wire

/* File: verification/iss_periph.sv */
`timescale 1ns/1ns
`default_nettype none
module iss_periph (
  input wire logic pclk,
  input wire logic [9:0] pat,
  output logic [9:0] src
);
  // on-chip sources move just after the edge, same clock
  always_ff @(posedge pclk) begin
    src <= pat;
  end
endmodule // iss_periph
`default_nettype wire

/* File: verification/iss_source_select_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module iss_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic fault1_pin,
  input wire logic fault2_pin,
  input wire logic timer_in2_pin,
  input wire logic timer_in3_pin,
  input wire logic comparator_a_out,
  input wire logic comparator_b_out,
  input wire logic pwm_reload_sync,
  input wire logic [11:0] adc_result_slot0,
  input wire logic [11:0] adc_result_slot2,
  input wire logic [11:0] high_limit_2,
  input wire logic [11:0] low_limit_2,
  input wire logic pwm_fault1_in,
  input wire logic pwm_fault2_in,
  input wire logic pair2_source,
  input wire logic [5:0] pwm_adc_force,
  input wire logic [5:0] pwm_adc_force_en,
  input wire logic timer_a_in2,
  input wire logic timer_a_in3
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [15:0] pwm_r, tmr_r;
  logic [1:0] up_r;
  wire wr = psel && penable && pwrite;
  // shadow selections; up_r masks the pin synchroniser fill after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_r <= '0;
      tmr_r <= '0;
      up_r <= '0;
    end else begin
      if (up_r != 2'h3) up_r <= up_r + 2'h1;
      if (wr && paddr == 12'h060) pwm_r <= pwdata[15:0];
      if (wr && paddr == 12'h068) tmr_r <= pwdata[15:0];
    end
  end
  property p_fault2;
    up_r == 2'h3 |->
      pwm_fault2_in == ($past(pwm_r[13]) ? $past(comparator_b_out) : $past(fault2_pin, 3));
  endproperty
  a_fault2: assert property (p_fault2) else $error("fault2 route");
  property p_fault1;
    up_r == 2'h3 |->
      pwm_fault1_in == ($past(pwm_r[11]) ? $past(comparator_a_out) : $past(fault1_pin, 3));
  endproperty
  a_fault1: assert property (p_fault1) else $error("fault1 route");
  property p_tin3;
    up_r == 2'h3 |->
      timer_a_in3 == ($past(tmr_r[12]) ? $past(pwm_reload_sync) : $past(timer_in3_pin, 3));
  endproperty
  a_tin3: assert property (p_tin3) else $error("timer in3 route");
  property p_tin2;
    up_r == 2'h3 |->
      timer_a_in2 == ($past(tmr_r[8]) ? $past(comparator_b_out) : $past(timer_in2_pin, 3));
  endproperty
  a_tin2: assert property (p_tin2) else $error("timer in2 route");
  property p_p2_cmpa;
    pwm_r[8:6] == 3'h3 |=> pair2_source == $past(comparator_a_out);
  endproperty
  a_p2_cmpa: assert property (p_p2_cmpa) else $error("pair2 cmp route");
  property p_p2_high;
    pwm_r[8:6] == 3'h2 && adc_result_slot2 > high_limit_2 |=>
      pwm_adc_force[5:4] == 2'h2 && pwm_adc_force_en[5:4] == 2'h3;
  endproperty
  a_p2_high: assert property (p_p2_high) else $error("pair2 high force");
  property p_p0_low;
    pwm_r[2:0] == 3'h2 && adc_result_slot0 < low_limit_2 |=>
      pwm_adc_force[1:0] == 2'h1 && pwm_adc_force_en[1:0] == 2'h3;
  endproperty
  a_p0_low: assert property (p_p0_low) else $error("pair0 low force");
  property p_p2_rsv;
    pwm_r[8:6] == 3'h0 || pwm_r[8:6] > 3'h4 |=> !pair2_source;
  endproperty
  a_p2_rsv: assert property (p_p2_rsv) else $error("pair2 reserved");
endmodule // iss_props
bind iss_source_select iss_props iss_props_i (.*);
`default_nettype wire

/* File: verification/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, rd, rm = 32'h14bbd, rs = 32'h14bbd;
  logic fault1_pin = 1'h0, fault2_pin = 1'h0, pair0_external_source = 1'h0;
  logic pair1_external_source = 1'h0, timer_in1_pin = 1'h0;
  logic timer_in2_pin = 1'h0, timer_in3_pin = 1'h0;
  logic [11:0] adc_result_slot0 = 12'h0, adc_result_slot1 = 12'h0, adc_result_slot2 = 12'h0;
  logic [11:0] high_limit_1 = 12'h800, high_limit_2 = 12'h900, low_limit_2 = 12'h400;
  logic [9:0] pat = 10'h0;
  logic [3:0] ex, ef;
  logic [5:0] pin_h = 6'h0;
  logic [31:0] msk [4] = '{32'h29ff, 32'h77, 32'h1110, 32'h0};
  wire [9:0] src;
  wire comparator_a_out, comparator_b_out, timer_a_ch0, timer_a_ch1, timer_a_ch2, timer_a_ch3;
  wire interval_timer_0, interval_timer_1, interval_timer_2, pwm_reload_sync, pready, pslverr;
  wire [31:0] prdata;
  wire pwm_fault1_in, pwm_fault2_in, pair0_source, pair1_source, pair2_source, dac0_sync_in;
  wire dac1_sync_in, timer_a_in1, timer_a_in2, timer_a_in3;
  wire [5:0] pwm_adc_force, pwm_adc_force_en;
  int num_errors = 0, total_checks = 0, k;
  assign {comparator_a_out, comparator_b_out, timer_a_ch0, timer_a_ch1, timer_a_ch2,
    timer_a_ch3, interval_timer_0, interval_timer_1, interval_timer_2, pwm_reload_sync} = src;
  iss_source_select iss_source_select_i (.*);
  iss_periph iss_periph_i (.pclk(pclk), .pat(pat), .src(src));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  function automatic logic dx(input logic [2:0] c, input logic [9:0] s);
    return c > 3'h5 ? 1'h0 : c[2] ? s[7 - c[0]] : s[3 - c[1:0]];
  endfunction
  function automatic logic px(input logic [2:0] c, input logic t, input logic [9:0] s);
    return c == 3'h1 ? t : c == 3'h3 ? s[9] : c == 3'h4 ? s[8] : 1'h0;
  endfunction
  function automatic logic [3:0] fx(input logic [11:0] r, input logic [11:0] h,
    input logic [11:0] l);
    return r > h ? 4'he : r < l ? 4'hd : 4'h0;
  endfunction
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'h1 && k < 20);
    if (k == 20) begin
      num_errors++;
      end_sim;
    end
    q = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  initial forever #50 pclk = ~pclk;
  always @(posedge pclk) begin
    rs = xs(rs);
    {fault1_pin, fault2_pin, pair0_external_source, pair1_external_source} <= rs[3:0];
    {timer_in1_pin, timer_in2_pin, timer_in3_pin} <= rs[6:4];
    pat <= rs[16:7];
    adc_result_slot0 <= rs[31:20];
    adc_result_slot1 <= rs[27:16];
    adc_result_slot2 <= rs[23:12];
  end
  // pins as sampled at the coming edge, then the two edges before
  always @(negedge pclk) begin
    pin_h <= {pin_h[3:0], timer_in1_pin, pair1_external_source};
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    for (int i = 0; i < 4; i++) begin
      apb(1'h0, 12'h060 + {i[9:0], 2'h0}, 32'h0, rd);
      chk(rd, 32'h0);
      apb(1'h1, 12'h060 + {i[9:0], 2'h0}, 32'hffffffff, rd);
      apb(1'h0, 12'h060 + {i[9:0], 2'h0}, 32'h0, rd);
      chk(rd, msk[i]);
    end
    $display("register test done");
    for (int c = 0; c < 8; c++) begin
      apb(1'h1, 12'h064, {25'h0, c[2:0], 1'h0, c[2:0]}, rd);
      apb(1'h1, 12'h060, {23'h0, c[2:0], 3'h0, c[2:0]}, rd);
      @(negedge pclk);
      ex = {dx(c[2:0], src), dx(c[2:0], src), px(c[2:0], src[4], src), px(c[2:0], src[7], src)};
      @(posedge pclk);
      #1;
      chk({dac1_sync_in, dac0_sync_in, pair2_source, pair0_source & (c != 0)}, ex);
    end
    $display("code test done");
    repeat (200) begin
      rm = xs(rm);
      apb(1'h1, 12'h060, rm & 32'h29ff, rd);
      apb(1'h1, 12'h068, (rm >> 16) & 32'h1110, rd);
      repeat (4) @(posedge pclk);
      @(negedge pclk);
      #1;
      ex = {2'h0, rm[20] ? src[9] : pin_h[5], rm[5:3] == 3'h0 ? pin_h[4] : px(rm[5:3], src[5], src)};
      ef = rm[5:3] == 3'h2 ? fx(adc_result_slot1, high_limit_1, low_limit_2) : 4'h0;
      @(posedge pclk);
      #1;
      chk({timer_a_in1, pair1_source}, ex);
      chk({pwm_adc_force_en[3:2], pwm_adc_force[3:2]}, ef);
    end
    $display("random test done");
    end_sim;
  end
endmodule // tb
`default_nettype wire
